//--- logic/btpm_top.sv
// btpm_top: base timer with periodic interrupt plus STOP/IDLE power-mode control.
// assumes an AHB-Lite master on hclk; core-side handshakes are on hclk, pins are not.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module btpm_top
  import btpm_pkg::*;
#(
  parameter int unsigned BTM_BASE = btpm_pkg::BTM_BASE_TICKS,
  parameter int unsigned LS_DIV   = btpm_pkg::LS_DIV_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_irq_first,
  input  wire logic        ext_irq_second,
  input  wire logic        ext_reset_n,
  input  wire logic        wdt_enable,
  input  wire logic        wdt_event,
  input  wire logic        cpu_irq_pending,
  input  wire logic        cpu_btm_ack,
  output logic             lsosc_en,
  output logic             hf_clk_en,
  output logic             cpu_halt,
  output logic             btm_irq_req,
  output logic             irq
);
  import btpm_pkg::*;

  // ==========================================================================
  // pin synchronisers
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [2:0] pin_raw;

  assign pin_raw = {ext_reset_n, ext_irq_second, ext_irq_first};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_meta_q[i] <= (i == 2) ? 1'b1 : 1'b0;
          pin_sync_q[i] <= (i == 2) ? 1'b1 : 1'b0;
        end else begin
          pin_meta_q[i] <= pin_raw[i];
          pin_sync_q[i] <= pin_meta_q[i];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // bus slave
  // reads take one wait state so a write in its data phase is always visible
  logic        wr_q;
  logic        rd_q;
  logic [11:0] addr_q;
  logic        addr_ok;
  logic        pwr_wr;
  logic        btm_wr;
  logic        st_wr;
  logic        mask_wr;
  logic        en_wr;
  logic [7:0]  wdat;

  assign addr_ok = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
  assign wdat    = hwdata[7:0];
  assign pwr_wr  = wr_q && (addr_q == ADDR_PWR);
  assign btm_wr  = wr_q && (addr_q == ADDR_BTM);
  assign st_wr   = wr_q && (addr_q == ADDR_STATUS);
  assign mask_wr = wr_q && (addr_q == ADDR_MASK);
  assign en_wr   = wr_q && (addr_q == ADDR_IRQ_EN);

  // kept as a register so every output leaves a flop; this slave never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_q <= addr_ok && hwrite;
      rd_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        addr_q <= haddr[11:0];
      end
    end
  end

  // ==========================================================================
  // base timer control and counter
  logic                 run_q;
  logic                 flag_q;
  logic [3:0]           sel_q;
  logic [BTM_CNT_W-1:0] btm_cnt_q;
  logic                 ls_tick;
  logic                 btm_ev;
  logic                 irq_en_q;

  function automatic logic [BTM_CNT_W-1:0] period_ticks(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > BTM_SEL_MAX) ? BTM_SEL_MAX : sel;
    return BTM_CNT_W'(BTM_BASE) << s;
  endfunction

  btpm_lsosc #(
    .DIV (LS_DIV)
  ) u_lsosc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (lsosc_en),
    .tick    (ls_tick)
  );

  assign btm_ev = run_q && ls_tick && (btm_cnt_q == period_ticks(sel_q) - 1'b1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= BTM_RESET[BTM_RUN_BIT];
      sel_q <= BTM_RESET[3:0];
    end else if (btm_wr) begin
      run_q <= wdat[BTM_RUN_BIT];
      sel_q <= wdat[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btm_cnt_q <= '0;
    end else if (!run_q) begin
      btm_cnt_q <= '0;
    end else if (ls_tick) begin
      btm_cnt_q <= btm_ev ? '0 : btm_cnt_q + 1'b1;
    end
  end

  // the period event wins over both the core's acknowledge and a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= BTM_RESET[BTM_FLAG_BIT];
    end else if (btm_ev) begin
      flag_q <= 1'b1;
    end else if (cpu_btm_ack) begin
      flag_q <= 1'b0;
    end else if (btm_wr) begin
      flag_q <= wdat[BTM_FLAG_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= 1'b0;
    end else if (en_wr) begin
      irq_en_q <= wdat[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btm_irq_req <= 1'b0;
    end else begin
      btm_irq_req <= irq_en_q && (btm_ev || (flag_q && !cpu_btm_ack));
    end
  end

  // ==========================================================================
  // power-mode sequencer
  btpm_state_t state_q;
  btpm_state_t state_d;
  btpm_wake_t  wake;
  logic        wake_any;

  assign wake.ext_first  = pin_sync_q[0];
  assign wake.ext_second = pin_sync_q[1];
  assign wake.ext_reset  = !pin_sync_q[2];
  assign wake.wdt        = wdt_event;
  assign wake.btm        = btm_ev;
  assign wake_any        = |wake;

  // the core does not halt until the write's data phase ends; the trailing
  // no-operations in software cover that slack
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_RUN: begin
        if (pwr_wr && wdat[PWR_STOP_BIT]) begin
          state_d = S_STOP;
        end else if (pwr_wr && wdat[PWR_IDLE_BIT]) begin
          state_d = S_IDLE;
        end
      end
      S_STOP: begin
        if (wake_any) begin
          state_d = S_WAKE;
        end
      end
      S_WAKE: begin
        state_d = S_RUN;
      end
      S_IDLE: begin
        if (cpu_irq_pending || btm_irq_req) begin
          state_d = S_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= S_RUN;
      hf_clk_en <= 1'b1;
      cpu_halt  <= 1'b0;
    end else begin
      state_q   <= state_d;
      hf_clk_en <= (state_d != S_STOP);
      cpu_halt  <= (state_d != S_RUN);
    end
  end

  // the oscillator ignores the power mode on purpose
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lsosc_en <= 1'b0;
    end else begin
      lsosc_en <= run_q || wdt_enable;
    end
  end

  // ==========================================================================
  // interrupt status and mask
  logic [2:0] status_q;
  logic [2:0] status_d;
  logic [2:0] mask_q;
  logic [2:0] mask_d;
  logic [2:0] ev;

  assign ev[EV_BTM]       = btm_ev;
  assign ev[EV_STOP_WAKE] = (state_q == S_STOP) && wake_any;
  assign ev[EV_IDLE_WAKE] = (state_q == S_IDLE) && (state_d == S_RUN);

  always_comb begin
    status_d = status_q;
    if (st_wr) begin
      status_d = status_q & ~wdat[2:0];
    end
    status_d = status_d | ev;
    mask_d   = mask_wr ? wdat[2:0] : mask_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= EV_RESET;
      mask_q   <= EV_RESET;
      irq      <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq      <= |(status_d & mask_d);
    end
  end

  // ==========================================================================
  // read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
    end else if (addr_ok && !hwrite) begin
      hreadyout <= 1'b0;
    end else if (rd_q) begin
      hreadyout <= 1'b1;
      unique case (addr_q)
        ADDR_BTM:    hrdata <= {24'h0, run_q, flag_q, 2'b00, sel_q};
        ADDR_STATUS: hrdata <= {29'h0, status_q};
        ADDR_MASK:   hrdata <= {29'h0, mask_q};
        ADDR_IRQ_EN: hrdata <= {31'h0, irq_en_q};
        ADDR_MODE:   hrdata <= {28'h0, lsosc_en, hf_clk_en, state_q == S_STOP, state_q == S_IDLE};
        default:     hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // checks
  stop_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pwr_wr && wdat[PWR_STOP_BIT] && state_q == S_RUN |=> !hf_clk_en && cpu_halt)
    else $error("stop write did not stop the fast clock");

  idle_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pwr_wr && !wdat[PWR_STOP_BIT] && wdat[PWR_IDLE_BIT] && state_q == S_RUN |=> cpu_halt && hf_clk_en)
    else $error("idle write did not halt with clock running");

  stop_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == S_STOP && wake_any |=> hf_clk_en && cpu_halt ##1 !cpu_halt)
    else $error("stop wake order wrong");

  idle_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == S_IDLE && cpu_irq_pending |=> !cpu_halt)
    else $error("idle did not end on interrupt");

  stop_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == S_STOP && !wake_any |=> !hf_clk_en)
    else $error("stop left without wake event");

  timer_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !run_q |=> btm_cnt_q == '0 && !btm_ev)
    else $error("timer counts while stopped");

  flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    btm_ev |=> flag_q && status_q[EV_BTM])
    else $error("period did not set flag");

  flag_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_btm_ack && !btm_ev |=> !flag_q)
    else $error("acknowledge did not clear flag");

  osc_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 lsosc_en == ($past(run_q) || $past(wdt_enable)))
    else $error("oscillator enable wrong");

  pwr_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_q && addr_q == ADDR_PWR |=> hrdata == 32'h0000_0000 && hreadyout)
    else $error("power register read not zero");

  irq_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(status_q & mask_q))
    else $error("interrupt output disagrees with status");

  btm_wake_c: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == S_STOP && btm_ev ##2 state_q == S_RUN);
  idle_trip_c: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == S_IDLE ##[1:50] state_q == S_RUN);
  flag_race_c: cover property (@(posedge hclk) disable iff (!hresetn)
    btm_ev && cpu_btm_ack);

endmodule

`default_nettype wire

//--- pkg/btpm_pkg.sv
// btpm_pkg: constants, types and register map of the base timer and power-mode block.
// assumes a single 40 MHz bus clock; the low-speed oscillator is modelled as an enable tick.

package btpm_pkg;

  // ==========================================================================
  // clocking and timing
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned LS_FREQ_HZ     = 128000;
  localparam int unsigned LS_DIV_CYCLES  = CLK_HZ / LS_FREQ_HZ;  // rounds down to 312
  localparam longint     BTM_BASE_PERIOD_NS = 15625000;          // 15.625ms
  localparam int unsigned BTM_BASE_TICKS =
    int'((BTM_BASE_PERIOD_NS * longint'(LS_FREQ_HZ)) / 64'd1000000000);
  localparam logic [3:0]  BTM_SEL_MAX    = 4'h8;                 // 4.0s
  localparam int unsigned BTM_CNT_W      = 19;                   // 2000 ticks << 8 needs 19 bits

  // ==========================================================================
  // register map: printed offsets are indexes, byte address is four times the index
  localparam logic [7:0]  IDX_PWR        = 8'h87;
  localparam logic [7:0]  IDX_BTM        = 8'hce;
  localparam logic [7:0]  IDX_STATUS     = 8'h10;
  localparam logic [7:0]  IDX_MASK       = 8'h11;
  localparam logic [7:0]  IDX_MODE       = 8'h12;
  localparam logic [7:0]  IDX_IRQ_EN     = 8'h13;
  localparam logic [11:0] ADDR_PWR       = {2'b00, IDX_PWR, 2'b00};
  localparam logic [11:0] ADDR_BTM       = {2'b00, IDX_BTM, 2'b00};
  localparam logic [11:0] ADDR_STATUS    = {2'b00, IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_MASK      = {2'b00, IDX_MASK, 2'b00};
  localparam logic [11:0] ADDR_MODE      = {2'b00, IDX_MODE, 2'b00};
  localparam logic [11:0] ADDR_IRQ_EN    = {2'b00, IDX_IRQ_EN, 2'b00};

  // ==========================================================================
  // field positions and reset values
  localparam int unsigned PWR_STOP_BIT   = 1;
  localparam int unsigned PWR_IDLE_BIT   = 0;
  localparam int unsigned BTM_RUN_BIT    = 7;
  localparam int unsigned BTM_FLAG_BIT   = 6;
  localparam logic [7:0]  BTM_RESET      = 8'h00;
  localparam logic [2:0]  EV_RESET       = 3'h0;
  localparam int unsigned EV_BTM         = 0;
  localparam int unsigned EV_STOP_WAKE   = 1;
  localparam int unsigned EV_IDLE_WAKE   = 2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {S_RUN, S_IDLE, S_STOP, S_WAKE} btpm_state_t;

  typedef struct packed {
    logic ext_first;
    logic ext_second;
    logic wdt;
    logic ext_reset;
    logic btm;
  } btpm_wake_t;

endpackage

//--- logic/btpm_lsosc.sv
// btpm_lsosc: low-speed oscillator model, one-cycle tick at about 128 kHz.
// assumes hclk domain; stopping the oscillator restarts the phase on the next start.
`timescale 1ns/1ps
`default_nettype none

module btpm_lsosc #(
  parameter int unsigned DIV = 312
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  output logic      tick
);
  import btpm_pkg::*;

  logic [15:0] cnt_q;

  // ==========================================================================
  // divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- test/btpm_top_tb.sv
// btpm_top_tb: self-checking bench for the base timer and power-mode block.
// assumes a lone AHB-Lite slave on hclk; the bench stands in for core, pins and watchdog.
`timescale 1ns/1ps
`default_nettype none

module btpm_top_tb;
  import btpm_pkg::*;

  // ==========================================================================
  // signals
  localparam int unsigned BASE = 4;
  localparam int unsigned DIV  = 2;
  logic        hclk, hresetn, hsel, hwrite, ext_irq_first, ext_irq_second, ext_reset_n;
  logic        wdt_enable, wdt_event, cpu_irq_pending, cpu_btm_ack;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, lsosc_en, hf_clk_en, cpu_halt, btm_irq_req, irq;
  wire logic   hready;
  int          fails, comparisons, cyc, t0;

  // one slave: its ready is the bus ready
  assign hready = hreadyout;

  btpm_top #(.BTM_BASE(BASE), .LS_DIV(DIV)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_irq_first(ext_irq_first),
    .ext_irq_second(ext_irq_second), .ext_reset_n(ext_reset_n), .wdt_enable(wdt_enable),
    .wdt_event(wdt_event), .cpu_irq_pending(cpu_irq_pending), .cpu_btm_ack(cpu_btm_ack),
    .lsosc_en(lsosc_en), .hf_clk_en(hf_clk_en), .cpu_halt(cpu_halt),
    .btm_irq_req(btm_irq_req), .irq(irq));

  always #12.5 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  // ==========================================================================
  // checks and bus tasks; values are read right after an edge, so they are pre-edge
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk(name, {31'h0, exp}, {31'h0, got});
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return hf_clk_en;
      1: return btm_irq_req;
      2: return cpu_halt;
      3: return lsosc_en;
      default: return irq;
    endcase
  endfunction

  task automatic wait_for(input int s, input logic v);
    int n;
    for (n = 0; n < 5000; n++) begin
      @(posedge hclk);
      if (sig(s) === v) break;
    end
    if (n == 5000) chk_bit("wait", v, sig(s));
  endtask

  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(name, exp, q);
    chk_bit("hresp", 1'b0, hresp);
  endtask

  task automatic ack();
    cpu_btm_ack <= 1'b1;
    @(posedge hclk);
    cpu_btm_ack <= 1'b0;
    @(posedge hclk);
    chk_bit("btm_irq_req after ack", 1'b0, btm_irq_req);
  endtask

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the tests need well under 40000 cycles
  initial begin
    #(25 * 60000);
    fails++;
    results();
  end

  // ==========================================================================
  // tests
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; ext_irq_first = 1'b0; ext_irq_second = 1'b0;
    ext_reset_n = 1'b1; wdt_enable = 1'b0; wdt_event = 1'b0; cpu_irq_pending = 1'b0;
    cpu_btm_ack = 1'b0; fails = 0; comparisons = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_bit("hf_clk_en reset", 1'b1, hf_clk_en);
    chk_bit("cpu_halt reset", 1'b0, cpu_halt);
    chk_bit("lsosc_en reset", 1'b0, lsosc_en);
    chk_bit("irq reset", 1'b0, irq);
    rd_chk(ADDR_BTM, 32'h0, "control reset");
    rd_chk(ADDR_PWR, 32'h0, "power reset");
    rd_chk(ADDR_MODE, 32'h4, "mode reset");
    wr(12'h100, 32'hff);
    rd_chk(12'h100, 32'h0, "unmapped");
    wr(ADDR_BTM, 32'h0f);
    rd_chk(ADDR_BTM, 32'h0f, "select field");
    wr(ADDR_BTM, 32'h30);
    rd_chk(ADDR_BTM, 32'h0, "reserved bits");
    repeat (40) @(posedge hclk);
    chk_bit("no event while stopped", 1'b0, btm_irq_req);
    // watchdog enable alone keeps the slow oscillator on
    wdt_enable <= 1'b1;
    wait_for(3, 1'b1);
    wdt_enable <= 1'b0;
    wait_for(3, 1'b0);
    // interval codes 0 to 9, code 9 behaves as code 8
    wr(ADDR_IRQ_EN, 32'h1);
    for (int s = 0; s < 10; s++) begin
      wr(ADDR_BTM, 32'h0);
      ack();
      wr(ADDR_BTM, {24'h0, 4'h8, s[3:0]});
      wait_for(1, 1'b1);
      t0 = cyc;
      if (s == 8) rd_chk(ADDR_BTM, 32'hc8, "flag set");
      ack();
      if (s == 8) rd_chk(ADDR_BTM, 32'h88, "flag cleared");
      chk_bit("lsosc_en running", 1'b1, lsosc_en);
      wait_for(1, 1'b1);
      chk("period", DIV * (BASE << ((s > 8) ? 8 : s)), cyc - t0);
    end
    wr(ADDR_BTM, 32'h0);
    ack();
    wait_for(3, 1'b0);
    // interrupt: sticky status, mask, write-one-to-clear
    rd_chk(ADDR_STATUS, 32'h1, "status period");
    chk_bit("irq masked", 1'b0, irq);
    wr(ADDR_MASK, 32'h1);
    wait_for(4, 1'b1);
    rd_chk(ADDR_MASK, 32'h1, "mask");
    wr(ADDR_STATUS, 32'h1);
    wait_for(4, 1'b0);
    rd_chk(ADDR_STATUS, 32'h0, "status cleared");
    // STOP entry and each wake source; both bits set once, STOP must win
    for (int w = 0; w < 5; w++) begin
      wdt_enable <= (w == 0);
      if (w == 4) wr(ADDR_BTM, 32'h80);
      wr(ADDR_PWR, (w == 3) ? 32'h3 : 32'h2);
      @(posedge hclk);
      chk_bit("hf_clk_en stop", 1'b0, hf_clk_en);
      chk_bit("cpu_halt stop", 1'b1, cpu_halt);
      chk_bit("lsosc_en stop", (w == 0 || w == 4), lsosc_en);
      if (w < 4) begin
        repeat (6) @(posedge hclk);
        chk_bit("stop holds", 1'b0, hf_clk_en);
      end
      case (w)
        0: ext_irq_first <= 1'b1;
        1: ext_irq_second <= 1'b1;
        2: wdt_event <= 1'b1;
        3: ext_reset_n <= 1'b0;
        default: ;
      endcase
      wait_for(0, 1'b1);
      chk_bit("halt at clock restart", 1'b1, cpu_halt);
      @(posedge hclk);
      chk_bit("halt released", 1'b0, cpu_halt);
      ext_irq_first  <= 1'b0;
      ext_irq_second <= 1'b0;
      wdt_event      <= 1'b0;
      ext_reset_n    <= 1'b1;
      wr(ADDR_BTM, 32'h0);
      ack();
      rd_chk(ADDR_PWR, 32'h0, "power unreadable");
      rd_chk(ADDR_STATUS, (w == 4) ? 32'h3 : 32'h2, "status wake");
      wr(ADDR_STATUS, 32'h7);
    end
    wdt_enable <= 1'b0;
    // IDLE: timer request disabled so only the pending core interrupt may resume
    wr(ADDR_IRQ_EN, 32'h0);
    wr(ADDR_BTM, 32'h80);
    wr(ADDR_PWR, 32'h1);
    @(posedge hclk);
    chk_bit("cpu_halt idle", 1'b1, cpu_halt);
    chk_bit("hf_clk_en idle", 1'b1, hf_clk_en);
    wait_for(4, 1'b1);
    chk_bit("req disabled", 1'b0, btm_irq_req);
    chk_bit("halt held", 1'b1, cpu_halt);
    cpu_irq_pending <= 1'b1;
    @(posedge hclk);
    @(posedge hclk);
    chk_bit("idle exit", 1'b0, cpu_halt);
    cpu_irq_pending <= 1'b0;
    wr(ADDR_BTM, 32'h0);
    ack();
    rd_chk(ADDR_STATUS, 32'h5, "status idle");
    results();
  end

endmodule

`default_nettype wire
